/* File: src/ptw_core.sv */
module ptw_core (
	input  wire logic                   i_clk,        // Bus clock
	input  wire logic                   i_rst_b,      // Async reset, low
	input  wire logic                   i_frame_b,    // Master frame, low
	input  wire logic                   i_irdy_b,     // Master ready, low
	input  wire logic                   i_req64_b,    // 64-bit request, low
	input  wire logic                   i_idsel,      // Configuration select
	input  wire logic [ptw_pkg::DW-1:0] i_ad,         // Address/data low
	input  wire logic [ptw_pkg::DW-1:0] i_ad_hi,      // Data high, 64-bit only
	input  wire logic [ptw_pkg::CW-1:0] i_cbe_b,      // Command/byte enables, low
	input  wire logic                   i_hit,        // Address decodes to us
	output wire logic                   o_devsel_b,   // Device select, low
	output wire logic                   o_trdy_b,     // Target ready, low
	output wire logic                   o_stop_b,     // Stop, low
	output wire logic                   o_ack64_b,    // 64-bit acknowledge, low
	output wire logic                   o_ctl_oe,     // Enable for the four controls
	output wire logic                   o_cfg_wr,     // Pulse: config dword written
	output wire logic [ptw_pkg::DW-1:0] o_cfg_data,   // Config write data
	ptw_local_if.core                   lif           // Local side
);
	typedef struct packed {
		ptw_pkg::ptw_state_e     state;
		logic [ptw_pkg::CW-1:0]  cmd;
		logic [ptw_pkg::DW-1:0]  addr;
		logic                    is32;
		logic                    cfg;
		logic                    rd;
		logic                    hi_next;
		logic                    rdy_seen;
		logic                    phase_done;
		logic                    disc_pend;
		logic                    burst;
		logic                    xfer;
		logic                    lframe;
		logic                    ack;
		logic                    ack_lo;
		logic                    ack_hi;
		logic [ptw_pkg::LDW-1:0] wdata;
		logic [3:0]              be;
		logic                    devsel;
		logic                    trdy;
		logic                    stop;
		logic                    ack64;
		logic                    oe;
		logic                    cfg_wr;
	} ptw_core_s;

	ptw_core_s st;
	ptw_core_s next_st;

	function automatic logic is_target_cmd(input logic [ptw_pkg::CW-1:0] c);
		is_target_cmd = (c == ptw_pkg::CMD_MEM_WR) || (c == ptw_pkg::CMD_IO_WR)
		             || (c == ptw_pkg::CMD_MEM_RD) || (c == ptw_pkg::CMD_IO_RD);
	endfunction : is_target_cmd

	function automatic logic is_read_cmd(input logic [ptw_pkg::CW-1:0] c);
		is_read_cmd = (c == ptw_pkg::CMD_MEM_RD) || (c == ptw_pkg::CMD_IO_RD)
		           || (c == ptw_pkg::CMD_CFG_RD);
	endfunction : is_read_cmd

	logic phase;
	logic rdy;
	logic term_ok;
	logic aligned_rd32;

	// ----------------------------------------
	// Target sequencing
	// ----------------------------------------
	always_comb begin
		next_st        = st;
		next_st.xfer   = 1'b0;
		next_st.ack    = 1'b0;
		next_st.ack_lo = 1'b0;
		next_st.ack_hi = 1'b0;
		next_st.cfg_wr = 1'b0;
		phase          = st.trdy && st.devsel && !i_irdy_b;
		rdy            = lif.local_target_ready;
		term_ok        = !st.cfg;
		aligned_rd32   = st.rd && st.is32
		              && (st.addr[ptw_pkg::QW_HI:ptw_pkg::QW_LO] == ptw_pkg::QW_ALIGN);
		// Local side pipeline: data phase seen on the bus lands next cycle
		if (phase) begin
			next_st.xfer       = 1'b1;
			next_st.phase_done = 1'b1;
			next_st.hi_next    = st.is32 ? !st.hi_next : st.hi_next;
			if (!st.cfg && !st.rd) begin
				next_st.ack              = 1'b1;
				next_st.ack_lo           = !st.is32 || !st.hi_next;
				next_st.ack_hi           = !st.is32 || st.hi_next;
				next_st.wdata[ptw_pkg::DW-1:0] = i_ad;
				next_st.wdata[ptw_pkg::LDW-1:ptw_pkg::DW] = st.is32 ? st.wdata[ptw_pkg::LDW-1:ptw_pkg::DW] : i_ad_hi;
				next_st.be               = ~i_cbe_b;
			end
			if (st.cfg && !st.rd) begin
				next_st.cfg_wr                 = 1'b1;
				next_st.wdata[ptw_pkg::DW-1:0] = i_ad;
			end
		end
		if (rdy && st.lframe) begin
			next_st.rdy_seen = 1'b1;
		end
		if ((st.state == ptw_pkg::ST_CLAIM || st.state == ptw_pkg::ST_DATA)
		    && !i_frame_b && !i_irdy_b) begin
			next_st.burst = 1'b1;
		end
		case (st.state)
			ptw_pkg::ST_IDLE: begin
				next_st.oe = 1'b0;
				if (!i_frame_b && i_hit) begin
					next_st.cmd        = ~i_cbe_b;
					next_st.addr       = i_ad;
					next_st.is32       = i_req64_b;
					next_st.cfg        = i_idsel;
					next_st.rd         = is_read_cmd(~i_cbe_b);
					next_st.hi_next    = (i_ad[ptw_pkg::QW_HI:ptw_pkg::QW_LO] == ptw_pkg::QW_HIGH);
					next_st.rdy_seen   = 1'b0;
					next_st.phase_done = 1'b0;
					next_st.disc_pend  = 1'b0;
					next_st.burst      = 1'b0;
					if (i_idsel || is_target_cmd(~i_cbe_b)) begin
						next_st.state  = ptw_pkg::ST_CLAIM;
						next_st.lframe = !i_idsel;
						next_st.oe     = 1'b1;
					end
				end
			end
			ptw_pkg::ST_CLAIM: begin
				next_st.devsel = 1'b1;
				next_st.ack64  = !st.is32;
				// First byte enables, early enough for the local I/O check
				next_st.be     = ~i_cbe_b;
				next_st.state  = ptw_pkg::ST_DATA;
			end
			ptw_pkg::ST_DATA: begin
				if (term_ok && lif.local_abort_req) begin
					next_st.devsel = 1'b0;
					next_st.trdy   = 1'b0;
					next_st.stop   = 1'b1;
					next_st.ack64  = 1'b0;
					next_st.state  = ptw_pkg::ST_STOP;
				end else if (term_ok && lif.local_disconnect_req && !aligned_rd32) begin
					if (!st.phase_done && !phase
					    && (st.rd ? !st.rdy_seen : !(st.rdy_seen || rdy))) begin
						next_st.trdy  = 1'b0;
						next_st.stop  = 1'b1;
						next_st.state = ptw_pkg::ST_STOP;
					end else if (!st.disc_pend) begin
						// One more phase may still complete, then stop
						next_st.disc_pend = 1'b1;
						next_st.stop      = 1'b1;
						next_st.trdy      = rdy && !phase;
						next_st.state     = ptw_pkg::ST_STOP;
					end
				end else begin
					next_st.trdy = st.cfg || rdy;
					if (phase && i_frame_b) begin
						next_st.trdy   = 1'b0;
						next_st.devsel = 1'b0;
						next_st.ack64  = 1'b0;
						next_st.state  = ptw_pkg::ST_TURN;
					end
				end
			end
			ptw_pkg::ST_STOP: begin
				if (phase) begin
					next_st.trdy = 1'b0;
				end
				if (i_frame_b) begin
					next_st.trdy   = 1'b0;
					next_st.stop   = 1'b0;
					next_st.devsel = 1'b0;
					next_st.ack64  = 1'b0;
					next_st.state  = ptw_pkg::ST_TURN;
				end
			end
			ptw_pkg::ST_TURN: begin
				next_st.oe     = 1'b0;
				next_st.lframe = 1'b0;
				next_st.state  = ptw_pkg::ST_IDLE;
			end
			default: begin
				next_st = '0;
				next_st.state = ptw_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st       <= '0;
			st.state <= ptw_pkg::ST_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign o_devsel_b = !st.devsel;
	assign o_trdy_b   = !st.trdy;
	assign o_stop_b   = !st.stop;
	assign o_ack64_b  = !st.ack64;
	assign o_ctl_oe   = st.oe;
	assign o_cfg_wr   = st.cfg_wr;
	assign o_cfg_data = st.wdata[ptw_pkg::DW-1:0];

	assign lif.local_frame_active = st.lframe;
	assign lif.local_target_ack   = st.ack;
	assign lif.local_xfer_strobe  = st.ack && lif.local_target_ready;
	assign lif.local_command_out  = st.cmd;
	assign lif.local_wr_data      = st.wdata;
	assign lif.local_addr         = st.addr;
	assign lif.local_byte_en      = st.be;
	assign lif.low_dword_ack      = st.ack_lo;
	assign lif.high_dword_ack     = st.ack_hi;

	always_comb begin
		lif.target_xfer_status_vector                    = '0;
		lif.target_xfer_status_vector[ptw_pkg::TS_REQ64]  = st.lframe && !st.is32;
		lif.target_xfer_status_vector[ptw_pkg::TS_ACTIVE] = st.devsel;
		lif.target_xfer_status_vector[ptw_pkg::TS_BURST]  = st.lframe && st.burst;
		lif.target_xfer_status_vector[ptw_pkg::TS_XFER]   = st.xfer;
	end
endmodule : ptw_core

/* File: src/ptw_pkg.sv */
package ptw_pkg;
	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int DW  = 32;
	localparam int LDW = 64;
	localparam int CW  = 4;
	localparam int TW  = 12;
	// ----------------------------------------
	// Status vector bit positions
	// ----------------------------------------
	localparam int TS_REQ64  = 7;
	localparam int TS_ACTIVE = 8;
	localparam int TS_BURST  = 9;
	localparam int TS_XFER   = 10;
	// ----------------------------------------
	// Bus commands
	// ----------------------------------------
	localparam logic [CW-1:0] CMD_IO_RD  = 4'h2;
	localparam logic [CW-1:0] CMD_IO_WR  = 4'h3;
	localparam logic [CW-1:0] CMD_MEM_RD = 4'h6;
	localparam logic [CW-1:0] CMD_MEM_WR = 4'h7;
	localparam logic [CW-1:0] CMD_CFG_RD = 4'hA;
	localparam logic [CW-1:0] CMD_CFG_WR = 4'hB;
	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	localparam int            QW_LO    = 0;
	localparam int            QW_HI    = 2;
	localparam logic [2:0]    QW_ALIGN = 3'h0;
	localparam logic [2:0]    QW_HIGH  = 3'h4;
	// ----------------------------------------
	// Target states
	// ----------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b0_0001,
		ST_CLAIM = 5'b0_0010,
		ST_DATA  = 5'b0_0100,
		ST_STOP  = 5'b0_1000,
		ST_TURN  = 5'b1_0000
	} ptw_state_e;
endpackage : ptw_pkg

/* File: src/ptw_local_if.sv */
interface ptw_local_if;
	logic                               local_frame_active;
	logic                               local_xfer_strobe;
	logic                               local_target_ready;
	logic                               local_target_ack;
	logic                               local_disconnect_req;
	logic                               local_abort_req;
	logic [ptw_pkg::CW-1:0]             local_command_out;
	logic [ptw_pkg::TW-1:0]             target_xfer_status_vector;
	logic [ptw_pkg::LDW-1:0]            local_wr_data;
	logic [ptw_pkg::DW-1:0]             local_addr;
	logic [3:0]                         local_byte_en;
	logic                               low_dword_ack;
	logic                               high_dword_ack;

	modport core (
		output local_frame_active, local_xfer_strobe, local_target_ack, local_command_out,
		       target_xfer_status_vector, local_wr_data, local_addr, local_byte_en,
		       low_dword_ack, high_dword_ack,
		input  local_target_ready, local_disconnect_req, local_abort_req
	);
	modport app (
		input  local_frame_active, local_xfer_strobe, local_target_ack, local_command_out,
		       target_xfer_status_vector, local_wr_data, local_addr, local_byte_en,
		       low_dword_ack, high_dword_ack,
		output local_target_ready, local_disconnect_req, local_abort_req
	);
endinterface : ptw_local_if

/* File: src/ptw_app.sv */
module ptw_app #(
	parameter int CNT_W = 8
) (
	input  wire logic                    i_clk,          // Clock
	input  wire logic                    i_rst_b,        // Async reset, low
	ptw_local_if.app                     lif,            // Local side of the core
	input  wire logic                    i_ready_en,     // Accept data when high
	input  wire logic                    i_no32_burst,   // Cannot take 32-bit bursts
	input  wire logic [CNT_W-1:0]        i_disc_count,   // Local transfers before disconnect, 0 = none
	input  wire logic [ptw_pkg::DW-1:0]  i_range_end,    // Last byte address decoded
	output wire logic [ptw_pkg::LDW-1:0] o_data,         // Last accepted local data
	output wire logic [1:0]              o_data_half,    // Valid halves, {high,low}
	output wire logic                    o_data_valid,   // Pulse on accepted transfer
	output wire logic [CNT_W-1:0]        o_local_count,  // Local transfers this transaction
	output wire logic [CNT_W-1:0]        o_pci_count     // Bus transfers this transaction
);
	typedef struct packed {
		logic [ptw_pkg::LDW-1:0] data;
		logic [1:0]              half;
		logic                    valid;
		logic [CNT_W-1:0]        lcnt;
		logic [CNT_W-1:0]        pcnt;
		logic [ptw_pkg::DW-1:0]  addr;
		logic                    disc;
		logic                    abort;
	} ptw_app_s;

	ptw_app_s st;
	ptw_app_s next_st;
	logic     io_bad;
	logic [ptw_pkg::DW-1:0] base;
	logic     is_io;
	logic     is_rd;

	// ----------------------------------------
	// Local transaction tracking
	// ----------------------------------------
	always_comb begin
		next_st       = st;
		next_st.valid = 1'b0;
		// Start address arrives with the frame, so use it until the first transfer
		base          = (st.lcnt == '0) ? lif.local_addr : st.addr;
		is_io = (lif.local_command_out == ptw_pkg::CMD_IO_WR) || (lif.local_command_out == ptw_pkg::CMD_IO_RD);
		is_rd = (lif.local_command_out == ptw_pkg::CMD_IO_RD) || (lif.local_command_out == ptw_pkg::CMD_MEM_RD);
		// Enabled byte below the addressed byte is an illegal I/O access
		io_bad = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (lif.local_byte_en[i] && (i < int'(lif.local_addr[1:0]))) begin
				io_bad = 1'b1;
			end
		end
		if (!lif.local_frame_active) begin
			next_st.lcnt  = '0;
			next_st.pcnt  = '0;
			next_st.disc  = 1'b0;
			next_st.abort = 1'b0;
			next_st.addr  = lif.local_addr;
		end else begin
			if (lif.target_xfer_status_vector[ptw_pkg::TS_XFER]) begin
				next_st.pcnt = st.pcnt + CNT_W'(1);
			end
			if (lif.local_xfer_strobe) begin
				next_st.lcnt  = st.lcnt + CNT_W'(1);
				next_st.data  = lif.local_wr_data;
				next_st.half  = {lif.high_dword_ack, lif.low_dword_ack};
				next_st.valid = 1'b1;
				next_st.addr  = base + ptw_pkg::DW'(4);
				if (is_io && io_bad) begin
					next_st.abort = 1'b1;
				end
				if (i_no32_burst && !lif.target_xfer_status_vector[ptw_pkg::TS_REQ64]
				    && lif.target_xfer_status_vector[ptw_pkg::TS_BURST]) begin
					next_st.disc = 1'b1;
				end
			end
			// Request ends with the data phase meant to be last
			if (i_disc_count != '0 && (st.lcnt + CNT_W'(1)) >= i_disc_count
			    && (lif.local_target_ready || !is_rd)) begin
				next_st.disc = 1'b1;
			end
			if (base + ptw_pkg::DW'(4) > i_range_end) begin
				next_st.disc = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign lif.local_target_ready   = i_ready_en && lif.local_frame_active;
	assign lif.local_disconnect_req = st.disc;
	// Bad I/O access must abort before its data phase completes
	assign lif.local_abort_req      = st.abort || (lif.local_frame_active && is_io && io_bad);
	assign o_data                   = st.data;
	assign o_data_half              = st.half;
	assign o_data_valid             = st.valid;
	assign o_local_count            = st.lcnt;
	assign o_pci_count              = st.pcnt;
endmodule : ptw_app

/* File: testbench/ptw_checker.sv */
module ptw_checker (
	input wire logic                        i_clk,                     // Clock
	input wire logic                        i_rst_b,                   // Reset, low
	input wire logic                        local_frame_active,        // Transaction open
	input wire logic                        local_xfer_strobe,         // Local transfer
	input wire logic                        local_target_ready,        // Local ready
	input wire logic                        local_target_ack,          // Data phase pulse
	input wire logic [ptw_pkg::CW-1:0]      local_command_out,         // Latched command
	input wire logic [ptw_pkg::TW-1:0]      target_xfer_status_vector, // Status
	input wire logic [ptw_pkg::DW-1:0]      local_addr,                // Start address
	input wire logic                        low_dword_ack,             // Low half valid
	input wire logic                        high_dword_ack             // High half valid
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	// ----
	// Half tracking within one transaction
	// ----
	logic seen;
	logic prev_low;
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			seen     <= 1'b0;
			prev_low <= 1'b0;
		end else if (!local_frame_active) begin
			seen <= 1'b0;
		end else if (local_target_ack) begin
			seen     <= 1'b1;
			prev_low <= low_dword_ack;
		end
	end
	sequence s_ack32;
		local_target_ack && !target_xfer_status_vector[ptw_pkg::TS_REQ64];
	endsequence
	// ----
	// Properties
	// ----
	a_one_half: assert property (s_ack32 |-> low_dword_ack != high_dword_ack)
		else $error("both or no dword halves acknowledged");
	a_first_half: assert property (s_ack32 ##0 !seen |-> low_dword_ack == !local_addr[2])
		else $error("first dword half does not match start address");
	a_halves_alternate: assert property (s_ack32 ##0 seen |-> high_dword_ack == prev_low)
		else $error("dword halves did not alternate");
	a_strobe_pair: assert property (local_xfer_strobe == (local_target_ack && local_target_ready))
		else $error("transfer strobe not ack and ready");
	a_ack_in_frame: assert property (local_target_ack |-> local_frame_active)
		else $error("local ack outside a local transaction");
	a_ack_status: assert property (local_target_ack |-> target_xfer_status_vector[ptw_pkg::TS_XFER])
		else $error("local ack without bus transfer status");
	a_burst_holds: assert property (local_frame_active && target_xfer_status_vector[ptw_pkg::TS_BURST] |=>
		!local_frame_active || target_xfer_status_vector[ptw_pkg::TS_BURST])
		else $error("burst status dropped mid transaction");
	a_cmd_steady: assert property (local_frame_active && $past(local_frame_active) |->
		$stable(local_command_out) && $stable(local_addr))
		else $error("command or address changed mid transaction");
	a_spare_bits: assert property (target_xfer_status_vector[6:0] == 7'h00 && !target_xfer_status_vector[11])
		else $error("unused status bits set");
endmodule : ptw_checker

/* File: testbench/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk, i_rst_b, frame_b, irdy_b, req64_b, idsel, hit, ready_en, no32;
	logic        devsel_b, trdy_b, stop_b, ack64_b, cfg_wr;
	logic        saw_stop, saw_a64, saw_dev, abort_seen, saw_burst, saw_r64, saw_cfg, app_valid;
	logic [63:0] app_data;
	logic [31:0] ad, ad_hi, range_end, cfg_data, a, wq[$], q_dat[$];
	logic [3:0]  cbe_b, q_cmd[$];
	logic [1:0]  q_half[$], app_half;
	logic [7:0]  disc_count, pci_count, loc_count, bus_cnt, lcl_cnt;
	int          failures, n_checks, seed, cycles, phases, n;
	ptw_local_if lif();
	ptw_core u_ptw_core (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_frame_b(frame_b), .i_irdy_b(irdy_b),
		.i_req64_b(req64_b), .i_idsel(idsel), .i_ad(ad), .i_ad_hi(ad_hi), .i_cbe_b(cbe_b), .i_hit(hit),
		.o_devsel_b(devsel_b), .o_trdy_b(trdy_b), .o_stop_b(stop_b), .o_ack64_b(ack64_b), .o_ctl_oe(),
		.o_cfg_wr(cfg_wr), .o_cfg_data(cfg_data), .lif(lif));
	ptw_app u_ptw_app (.i_clk(i_clk), .i_rst_b(i_rst_b), .lif(lif), .i_ready_en(ready_en), .i_no32_burst(no32),
		.i_disc_count(disc_count), .i_range_end(range_end), .o_data(app_data), .o_data_half(app_half),
		.o_data_valid(app_valid), .o_local_count(loc_count), .o_pci_count(pci_count));
	ptw_checker u_ptw_checker (.i_clk(i_clk), .i_rst_b(i_rst_b), .local_frame_active(lif.local_frame_active),
		.local_xfer_strobe(lif.local_xfer_strobe), .local_target_ready(lif.local_target_ready),
		.local_target_ack(lif.local_target_ack), .local_command_out(lif.local_command_out),
		.target_xfer_status_vector(lif.target_xfer_status_vector), .local_addr(lif.local_addr),
		.low_dword_ack(lif.low_dword_ack), .high_dword_ack(lif.high_dword_ack));
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	// ----
	// Shared tasks
	// ----
	task automatic close_out();
		$display("checks %0d, failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	// Bus master: one transaction of up to cnt data phases
	task automatic tx(input logic [3:0] cmd, input logic [31:0] addr, input int cnt, input logic r64,
		input logic cfg);
		int g;
		int act;
		wq.delete();
		q_dat.delete();
		q_half.delete();
		q_cmd.delete();
		for (int k = 0; k <= cnt; k++) wq.push_back($random(seed));
		{saw_stop, saw_a64, saw_dev, abort_seen, saw_burst, saw_r64, saw_cfg} = 7'h00;
		{bus_cnt, lcl_cnt} = 16'h0000;
		phases = 0;
		frame_b <= 1'b0;
		ad      <= addr;
		cbe_b   <= ~cmd;
		hit     <= 1'b1;
		idsel   <= cfg;
		req64_b <= ~r64;
		@(posedge i_clk);
		hit    <= 1'b0;
		idsel  <= 1'b0;
		irdy_b <= 1'b0;
		ad     <= wq[0];
		ad_hi  <= ~wq[0];
		cbe_b  <= 4'h0;
		if (cnt == 1) begin
			frame_b <= 1'b1;
			req64_b <= 1'b1;
		end
		for (g = 0; g < 40; g++) begin
			@(negedge i_clk);
			act = 0;
			if (frame_b && (!trdy_b || !stop_b)) act = 1;
			else if (!trdy_b) act = 2;
			else if (!stop_b) act = 3;
			if (!trdy_b) phases++;
			@(posedge i_clk);
			if (act == 1) break;
			if (act == 2) begin
				ad    <= wq[phases];
				ad_hi <= ~wq[phases];
			end
			if (act == 3 || (act == 2 && (phases == cnt - 1 || !stop_b))) begin
				frame_b <= 1'b1;
				req64_b <= 1'b1;
			end
		end
		irdy_b <= 1'b1;
		if (g >= 40) chk("transaction end", 1, 0);
		repeat (4) @(posedge i_clk);
	endtask : tx
	task automatic chk_wr(input logic [31:0] addr, input int cnt, input logic [3:0] cmd);
		chk("local words", cnt, q_dat.size());
		for (int k = 0; k < q_dat.size() && k < cnt; k++) begin
			chk("low half data", wq[k], q_dat[k]);
			chk("dword half", (addr[2] ^ k[0]) ? 2'b10 : 2'b01, q_half[k]);
			chk("command", cmd, q_cmd[k]);
		end
		chk("bus count", cnt, {24'h00_0000, bus_cnt});
		chk("local count", cnt, {24'h00_0000, lcl_cnt});
	endtask : chk_wr
	// ----
	// Monitor and timeout
	// ----
	always @(negedge i_clk) begin
		cycles++;
		if (!devsel_b) saw_dev = 1'b1;
		if (!ack64_b) saw_a64 = 1'b1;
		if (!stop_b) saw_stop = 1'b1;
		if (!stop_b && devsel_b) abort_seen = 1'b1;
		if (lif.target_xfer_status_vector[9]) saw_burst = 1'b1;
		if (lif.local_frame_active && lif.target_xfer_status_vector[7]) saw_r64 = 1'b1;
		if (cfg_wr) saw_cfg = (cfg_data === wq[0]);
		// Counts clear when the local frame ends, so keep the last nonzero value
		if (pci_count != 8'h00) bus_cnt = pci_count;
		if (loc_count != 8'h00) lcl_cnt = loc_count;
		if (app_valid === 1'b1 && q_dat.size() > 0) begin
			chk("app data", q_dat[q_dat.size()-1], app_data[31:0]);
			chk("app half", q_half[q_half.size()-1], {30'h0000_0000, app_half});
		end
		if (lif.local_target_ack === 1'b1) begin
			q_dat.push_back(lif.local_wr_data[31:0]);
			q_half.push_back({lif.high_dword_ack, lif.low_dword_ack});
			q_cmd.push_back(lif.local_command_out);
		end
		if (cycles > 20000) begin
			failures++;
			close_out();
		end
	end
	// ----
	// Scenarios
	// ----
	initial begin
		{seed, failures, n_checks, cycles} = {32'd48652, 96'h0};
		{i_rst_b, frame_b, irdy_b, req64_b, idsel, hit, ready_en, no32} = 8'h7A;
		{ad, ad_hi, cbe_b, disc_count, range_end} = {76'h0, 32'hFFFF_FFFF};
		repeat (6) @(posedge i_clk);
		i_rst_b <= 1'b1;
		@(posedge i_clk);
		for (int r = 0; r < 12; r++) begin
			n = 1 + ({$random(seed)} % 5);
			a = (r == 0) ? 32'h0000_0204 : ({$random(seed)} & 32'h0000_FFFC);
			tx(ptw_pkg::CMD_MEM_WR, a, n, 1'b0, 1'b0);
			chk_wr(a, n, ptw_pkg::CMD_MEM_WR);
			chk("stop", 0, saw_stop);
			chk("64-bit ack", 0, saw_a64);
			chk("claim", 1, saw_dev);
			chk("64-bit status", 0, saw_r64);
			chk("burst status", n > 1, saw_burst);
		end
		tx(ptw_pkg::CMD_IO_WR, 32'h0000_0010, 1, 1'b0, 1'b0);
		chk_wr(32'h0000_0010, 1, ptw_pkg::CMD_IO_WR);
		tx(ptw_pkg::CMD_MEM_WR, 32'h0000_0300, 2, 1'b1, 1'b0);
		chk("64-bit ack", 1, saw_a64);
		chk("64-bit status", 1, saw_r64);
		ready_en  <= 1'b0;
		range_end <= 32'h0000_0000;
		tx(ptw_pkg::CMD_CFG_WR, 32'h0000_0010, 1, 1'b0, 1'b1);
		chk("config phases", 1, phases);
		chk("config data", 1, saw_cfg);
		chk("config stop", 0, saw_stop);
		chk("config local words", 0, q_dat.size());
		tx(ptw_pkg::CMD_MEM_WR, 32'h0000_0400, 2, 1'b0, 1'b0);
		chk("retry stop", 1, saw_stop);
		chk("retry claim", 1, saw_dev);
		chk("retry phases", 0, phases);
		chk("retry claim held", 0, abort_seen);
		ready_en <= 1'b1;
		tx(ptw_pkg::CMD_MEM_RD, 32'h0000_0040, 1, 1'b0, 1'b0);
		chk("aligned read stop", 0, saw_stop);
		chk("aligned read phases", 1, phases);
		range_end  <= 32'hFFFF_FFFF;
		disc_count <= 8'h02;
		tx(ptw_pkg::CMD_MEM_WR, 32'h0000_0500, 6, 1'b0, 1'b0);
		chk("disconnect stop", 1, saw_stop);
		chk("disconnect phases", 1, phases >= 2 && phases < 6);
		chk("disconnect words", phases, q_dat.size());
		disc_count <= 8'h00;
		no32       <= 1'b1;
		tx(ptw_pkg::CMD_MEM_WR, 32'h0000_0600, 4, 1'b0, 1'b0);
		chk("burst refusal stop", 1, saw_stop);
		chk("burst refusal phases", 3, phases);
		no32 <= 1'b0;
		tx(ptw_pkg::CMD_IO_WR, 32'h0000_0013, 1, 1'b0, 1'b0);
		chk("abort stop", 1, saw_stop);
		chk("abort local words", 0, q_dat.size());
		chk("abort claim dropped", 1, abort_seen);
		close_out();
	end
endmodule : testbench
